// file: hdl/rsg_pkg.sv
package rsg_pkg;

  // Register byte addresses
  localparam logic [15:0] ADDR_PROCESSOR_MODE_0 = 16'h0004;
  localparam logic [15:0] ADDR_WRITE_GUARD_CONTROL = 16'h000a;
  localparam logic [15:0] ADDR_RESET_CAUSE_FLAGS = 16'h0018;
  localparam logic [15:0] ADDR_OPTION_SELECT_BYTE = 16'h0020;
  localparam logic [15:0] ADDR_IRQ_STATUS = 16'h0024;
  localparam logic [15:0] ADDR_IRQ_ENABLE = 16'h0028;
  localparam logic [15:0] ADDR_IRQ_CLEAR = 16'h002c;

  // Write guard control fields
  localparam int GUARD_ZERO_BIT = 0;
  localparam int GUARD_MODE_REGS_BIT = 1;
  localparam int GUARD_ONE_SHOT_BIT = 2;
  localparam int GUARD_THREE_BIT = 3;
  localparam int GUARD_SIX_BIT = 6;
  localparam logic [7:0] GUARD_STICKY_MASK = 8'h4b;

  // Processor mode 0 fields
  localparam int SOFTWARE_RESET_BIT = 3;
  localparam logic [7:0] PROCESSOR_MODE_0_RESET = 8'h00;
  localparam logic [7:0] PROCESSOR_MODE_0_STORE_MASK = 8'hf7;

  // Reset cause flag fields
  localparam int PIN_RESET_FLAG_BIT = 1;
  localparam int SOFT_RESET_FLAG_BIT = 2;
  localparam int WATCHDOG_RESET_FLAG_BIT = 3;
  localparam int MONITOR_TWO_RESET_FLAG_BIT = 5;
  localparam int OSC_STOP_RESET_FLAG_BIT = 6;

  // Option select byte
  localparam logic [7:0] OPTION_SELECT_BYTE_ERASED = 8'hff;
  localparam int MONITOR_ZERO_START_OPTION_BIT = 6;

  // Interrupt status fields
  localparam int IRQ_BLOCKED_WRITE_BIT = 0;
  localparam int IRQ_RESET_DONE_BIT = 1;
  localparam int IRQ_OSC_STOP_BIT = 2;
  localparam int IRQ_WIDTH = 3;

  // Release delay in slow internal oscillator cycles
  localparam int RELEASE_SLOW_CYCLES = 128;
  localparam int RELEASE_COUNT_WIDTH = 8;

  // Asynchronous inputs through the synchroniser
  localparam int SYNC_WIDTH = 5;

  typedef enum logic [2:0] {
    CAUSE_POWER,
    CAUSE_PIN,
    CAUSE_MON2,
    CAUSE_OSC,
    CAUSE_WDT,
    CAUSE_SOFT,
    CAUSE_NONE
  } rsg_cause_t;

  typedef struct packed {
    logic general;
    logic detector_cfg;
    logic level_select;
    logic clock_ctl;
  } rsg_group_reset_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rsg_bus_req_t;

endpackage

// file: hdl/rsg_release_counter.sv
`timescale 1ns/100ps
module rsg_release_counter
  import rsg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic tick,
  output logic done
);

  logic [RELEASE_COUNT_WIDTH-1:0] count_reg;

  always_ff @(posedge clk) begin
    if (rst || clear) begin
      count_reg <= '0;
    end else if (tick && !done) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  assign done = (count_reg == RELEASE_COUNT_WIDTH'(RELEASE_SLOW_CYCLES));

endmodule

// file: hdl/rsg_reset_guard.sv
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
module rsg_reset_guard
  import rsg_pkg::*;
#(
  parameter logic [7:0] OPTION_SELECT_BYTE = OPTION_SELECT_BYTE_ERASED
)
(
  input wire logic clk,
  input wire logic rst,
  input wire rsg_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  input wire logic reset_pin_n,
  input wire logic supply_below_first_level,
  input wire logic monitor_two_trip,
  input wire logic osc_stopped,
  input wire logic slow_internal_osc_clock,
  input wire logic watchdog_underflow,
  input wire logic reset_on_osc_stop_select,
  input wire logic monitor_zero_sw_enable,
  input wire logic other_sfr_write,
  output logic internal_reset,
  output rsg_group_reset_t group_reset,
  output logic guard_enable_zero,
  output logic guard_enable_mode_regs,
  output logic guard_enable_one_shot,
  output logic guard_enable_three,
  output logic guard_enable_six,
  output logic [7:0] processor_mode_0_out,
  output logic irq
);

  typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_COUNT} rsg_state_t;

  function automatic rsg_cause_t pick_cause(input logic pw, input logic pin, input logic m2,
                                            input logic osc, input logic wdt, input logic sw);
    rsg_cause_t c;
    c = CAUSE_NONE;
    if (pw) begin
      c = CAUSE_POWER;
    end else if (pin) begin
      c = CAUSE_PIN;
    end else if (m2) begin
      c = CAUSE_MON2;
    end else if (osc) begin
      c = CAUSE_OSC;
    end else if (wdt) begin
      c = CAUSE_WDT;
    end else if (sw) begin
      c = CAUSE_SOFT;
    end
    return c;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Synchronisers for the pin, the analog detector outputs and the slow oscillator clock

  logic [SYNC_WIDTH-1:0] async_in, sync_a_reg, sync_b_reg;
  logic slow_osc_prev_reg;

  assign async_in = {slow_internal_osc_clock, osc_stopped, monitor_two_trip,
                     supply_below_first_level, reset_pin_n};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_WIDTH; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (rst) begin
          sync_a_reg[gi] <= 1'b0;
          sync_b_reg[gi] <= 1'b0;
        end else begin
          sync_a_reg[gi] <= async_in[gi];
          sync_b_reg[gi] <= sync_a_reg[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      slow_osc_prev_reg <= 1'b0;
    end else begin
      slow_osc_prev_reg <= sync_b_reg[4];
    end
  end

  logic pin_src, power_src, mon2_src, osc_stop_s, slow_tick;

  // Pin reads low until the synchroniser has filled, which looks like a pin reset
  assign pin_src = !sync_b_reg[0];
  assign power_src = sync_b_reg[1];
  assign mon2_src = sync_b_reg[2];
  assign osc_stop_s = sync_b_reg[3];
  assign slow_tick = sync_b_reg[4] && !slow_osc_prev_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Reset source merging and sequencing

  rsg_state_t state_reg;
  rsg_cause_t cause_reg, new_cause;
  logic osc_latch_reg, wdt_pend_reg, soft_pend_reg, soft_req;
  logic level_active, count_done, release_now;

  // Stop detection only resets when the select bit is low
  // Latch oscillator stop
  always_ff @(posedge clk) begin
    if (rst || power_src || pin_src) begin
      osc_latch_reg <= 1'b0;
    end else if (osc_stop_s && !reset_on_osc_stop_select) begin
      osc_latch_reg <= 1'b1;
    end
  end

  // Event sources are held until the sequencer has taken them
  always_ff @(posedge clk) begin
    if (rst || state_reg != ST_RUN) begin
      wdt_pend_reg <= 1'b0;
      soft_pend_reg <= 1'b0;
    end else begin
      wdt_pend_reg <= wdt_pend_reg | watchdog_underflow;
      soft_pend_reg <= soft_pend_reg | soft_req;
    end
  end

  assign level_active = power_src || pin_src || mon2_src || osc_latch_reg;
  assign new_cause = pick_cause(power_src, pin_src, mon2_src, osc_latch_reg,
                                wdt_pend_reg, soft_pend_reg);
  assign release_now = (state_reg == ST_COUNT) && count_done && !level_active;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_HOLD;
      cause_reg <= CAUSE_POWER;
    end else begin
      case (state_reg)
        ST_RUN: begin
          if (new_cause != CAUSE_NONE) begin
            state_reg <= ST_HOLD;
            cause_reg <= new_cause;
          end
        end
        ST_HOLD: begin
          if (!level_active) begin
            state_reg <= ST_COUNT;
          end
          if (new_cause < cause_reg) begin
            cause_reg <= new_cause;
          end
        end
        ST_COUNT: begin
          if (level_active) begin
            state_reg <= ST_HOLD;
            if (new_cause < cause_reg) begin
              cause_reg <= new_cause;
            end
          end else if (count_done) begin
            state_reg <= ST_RUN;
          end
        end
        default: begin
          state_reg <= ST_HOLD;
        end
      endcase
    end
  end

  rsg_release_counter u_release (
    .clk(clk),
    .rst(rst),
    .clear(state_reg != ST_COUNT),
    .tick(slow_tick),
    .done(count_done)
  );

  assign internal_reset = (state_reg != ST_RUN);

  // Detector groups kept on lesser resets
  // Clock bits kept on osc stop only
  always_comb begin
    group_reset.general = internal_reset;
    group_reset.detector_cfg = internal_reset &&
                               (cause_reg == CAUSE_POWER || cause_reg == CAUSE_PIN);
    group_reset.level_select = internal_reset &&
                               (cause_reg == CAUSE_POWER || cause_reg == CAUSE_PIN ||
                                cause_reg == CAUSE_MON2);
    group_reset.clock_ctl = internal_reset && (cause_reg != CAUSE_OSC);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic wr_any, wr_guard, wr_mode, wr_flags;
  logic wr_enable, wr_clear, mode_blocked;

  // Bus writes are ignored while the processor is held in reset
  assign wr_any = bus_req.wr && !internal_reset;
  assign wr_guard = wr_any && bus_req.addr == ADDR_WRITE_GUARD_CONTROL;
  assign wr_mode = wr_any && bus_req.addr == ADDR_PROCESSOR_MODE_0;
  assign wr_flags = wr_any && bus_req.addr == ADDR_RESET_CAUSE_FLAGS;
  assign wr_enable = wr_any && bus_req.addr == ADDR_IRQ_ENABLE;
  assign wr_clear = wr_any && bus_req.addr == ADDR_IRQ_CLEAR;

  //////////////////////////////////////////////////////////////////////////////
  // Write guard control

  logic [7:0] guard_reg;

  always_ff @(posedge clk) begin
    if (rst || internal_reset) begin
      guard_reg <= 8'h00;
    end else begin
      if (wr_guard) begin
        guard_reg <= bus_req.wdata & GUARD_STICKY_MASK;
        guard_reg[GUARD_ONE_SHOT_BIT] <= bus_req.wdata[GUARD_ONE_SHOT_BIT];
      end else if (wr_any || other_sfr_write) begin
        guard_reg[GUARD_ONE_SHOT_BIT] <= 1'b0;
      end
    end
  end

  assign guard_enable_zero = guard_reg[GUARD_ZERO_BIT];
  assign guard_enable_mode_regs = guard_reg[GUARD_MODE_REGS_BIT];
  assign guard_enable_one_shot = guard_reg[GUARD_ONE_SHOT_BIT];
  assign guard_enable_three = guard_reg[GUARD_THREE_BIT];
  assign guard_enable_six = guard_reg[GUARD_SIX_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // Processor mode 0

  logic [7:0] mode_reg;

  assign mode_blocked = wr_mode && !guard_reg[GUARD_MODE_REGS_BIT];
  assign soft_req = wr_mode && guard_reg[GUARD_MODE_REGS_BIT] &&
                    bus_req.wdata[SOFTWARE_RESET_BIT];

  always_ff @(posedge clk) begin
    if (rst || internal_reset) begin
      mode_reg <= PROCESSOR_MODE_0_RESET;
    end else if (wr_mode && guard_reg[GUARD_MODE_REGS_BIT]) begin
      mode_reg <= bus_req.wdata & PROCESSOR_MODE_0_STORE_MASK;
    end
  end

  assign processor_mode_0_out = mode_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Reset cause flags, kept across internal resets

  logic pin_flag_reg, soft_flag_reg, wdt_flag_reg;
  logic mon2_flag_reg, osc_flag_reg, monitor_zero_enabled;

  assign monitor_zero_enabled = !OPTION_SELECT_BYTE[MONITOR_ZERO_START_OPTION_BIT] ||
                                monitor_zero_sw_enable;

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_flag_reg <= 1'b0;
      soft_flag_reg <= 1'b0;
      wdt_flag_reg <= 1'b0;
      mon2_flag_reg <= 1'b0;
    end else if (release_now) begin
      pin_flag_reg <= (cause_reg == CAUSE_PIN) && !monitor_zero_enabled;
      soft_flag_reg <= (cause_reg == CAUSE_SOFT);
      wdt_flag_reg <= (cause_reg == CAUSE_WDT);
      mon2_flag_reg <= (cause_reg == CAUSE_MON2);
    end
  end

  // Hardware set from osc_latch_reg wins over a software clear in the same cycle
  // Pin reset keeps osc flag
  always_ff @(posedge clk) begin
    if (rst) begin
      osc_flag_reg <= 1'b0;
    end else if (release_now && cause_reg != CAUSE_PIN) begin
      osc_flag_reg <= (cause_reg == CAUSE_OSC);
    end else if (osc_latch_reg) begin
      osc_flag_reg <= 1'b1;
    end else if (wr_flags && !bus_req.wdata[OSC_STOP_RESET_FLAG_BIT]) begin
      osc_flag_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupts

  logic [IRQ_WIDTH-1:0] irq_status_reg, irq_enable_reg, irq_event;

  assign irq_event = {osc_stop_s, release_now, mode_blocked};

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~(wr_clear ? bus_req.wdata[IRQ_WIDTH-1:0] : '0))
                        | irq_event;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_enable_reg <= '0;
    end else if (wr_enable) begin
      irq_enable_reg <= bus_req.wdata[IRQ_WIDTH-1:0];
    end
  end

  assign irq = |(irq_status_reg & irq_enable_reg);

  //////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe

  logic [7:0] rdata_next;

  always_comb begin
    rdata_next = 8'h00;
    case (bus_req.addr)
      ADDR_PROCESSOR_MODE_0: rdata_next = mode_reg;
      ADDR_WRITE_GUARD_CONTROL: rdata_next = guard_reg;
      ADDR_RESET_CAUSE_FLAGS: begin
        rdata_next[PIN_RESET_FLAG_BIT] = pin_flag_reg;
        rdata_next[SOFT_RESET_FLAG_BIT] = soft_flag_reg;
        rdata_next[WATCHDOG_RESET_FLAG_BIT] = wdt_flag_reg;
        rdata_next[MONITOR_TWO_RESET_FLAG_BIT] = mon2_flag_reg;
        rdata_next[OSC_STOP_RESET_FLAG_BIT] = osc_flag_reg;
      end
      ADDR_OPTION_SELECT_BYTE: rdata_next = OPTION_SELECT_BYTE;
      ADDR_IRQ_STATUS: rdata_next[IRQ_WIDTH-1:0] = irq_status_reg;
      ADDR_IRQ_ENABLE: rdata_next[IRQ_WIDTH-1:0] = irq_enable_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst || !bus_req.rd) begin
      bus_rdata <= 8'h00;
    end else begin
      bus_rdata <= rdata_next;
    end
  end

endmodule

// file: tb/rsg_reset_guard_props.sv
`timescale 1ns/100ps
module rsg_reset_guard_props
  import rsg_pkg::*;
#(
  parameter logic [7:0] OPTION_SELECT_BYTE = OPTION_SELECT_BYTE_ERASED
)
(
  input wire logic clk,
  input wire logic rst,
  input wire rsg_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic reset_pin_n,
  input wire logic supply_below_first_level,
  input wire logic monitor_two_trip,
  input wire logic slow_internal_osc_clock,
  input wire logic watchdog_underflow,
  input wire logic other_sfr_write,
  input wire logic internal_reset,
  input wire rsg_group_reset_t group_reset,
  input wire logic guard_enable_mode_regs,
  input wire logic guard_enable_one_shot,
  input wire logic [7:0] processor_mode_0_out,
  input wire logic irq
);
  logic slow_p;
  logic slow_s;
  logic slow_q;
  logic [8:0] slow_edges;
  logic guard_wr;
  logic mode_wr;
  logic any_wr;
  assign guard_wr = bus_req.wr && (bus_req.addr == ADDR_WRITE_GUARD_CONTROL);
  assign mode_wr = bus_req.wr && (bus_req.addr == ADDR_PROCESSOR_MODE_0);
  assign any_wr = (other_sfr_write || bus_req.wr) && !guard_wr;
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    slow_p <= slow_internal_osc_clock;
    slow_s <= slow_p;
    slow_q <= slow_s;
  end
  // Same two-stage lag as the design, counted from the first cycle reset is seen,
  // so this count never falls below the design's own
  always_ff @(posedge clk) begin
    if (rst || !internal_reset || !reset_pin_n || supply_below_first_level || monitor_two_trip) begin
      slow_edges <= 9'h000;
    end else if (slow_s && !slow_q && (slow_edges != 9'h1ff)) begin
      slow_edges <= slow_edges + 9'h001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_sticky_guard;
    guard_enable_mode_regs && !guard_wr && !internal_reset |=> guard_enable_mode_regs || internal_reset;
  endproperty
  a_sticky_guard: assert property (p_sticky_guard) else $error("sticky guard bit dropped");
  property p_one_shot;
    guard_enable_one_shot && any_wr && !internal_reset |=> !guard_enable_one_shot;
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("one-shot guard bit kept");
  property p_mode_blocked;
    mode_wr && !guard_enable_mode_regs && !internal_reset |=> $stable(processor_mode_0_out) || internal_reset;
  endproperty
  a_mode_blocked: assert property (p_mode_blocked) else $error("unguarded mode write taken");
  property p_soft_reset;
    mode_wr && bus_req.wdata[SOFTWARE_RESET_BIT] && guard_enable_mode_regs && !internal_reset |-> ##2 internal_reset;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("software reset missing");
  property p_wdt_reset;
    watchdog_underflow && !internal_reset |-> ##[1:4] internal_reset;
  endproperty
  a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog reset missing");
  property p_general;
    internal_reset |-> group_reset.general;
  endproperty
  a_general: assert property (p_general) else $error("general group not reset");
  property p_osc_keeps;
    internal_reset && !group_reset.clock_ctl |-> !group_reset.detector_cfg && !group_reset.level_select;
  endproperty
  a_osc_keeps: assert property (p_osc_keeps) else $error("osc stop reset groups wrong");
  property p_nested;
    group_reset.detector_cfg |-> group_reset.level_select;
  endproperty
  a_nested: assert property (p_nested) else $error("level select kept while detector reset");
  property p_release;
    $fell(internal_reset) |-> slow_edges >= 9'd128;
  endproperty
  a_release: assert property (p_release) else $error("reset released too early");
  property p_option;
    $past(bus_req.rd) && ($past(bus_req.addr) == ADDR_OPTION_SELECT_BYTE) |-> bus_rdata == OPTION_SELECT_BYTE;
  endproperty
  a_option: assert property (p_option) else $error("option byte read wrong");
  property p_reserved;
    $past(bus_req.rd) && ($past(bus_req.addr) == ADDR_RESET_CAUSE_FLAGS) |-> (bus_rdata & 8'h91) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved flag bits not zero");
  c_soft: cover property (internal_reset && group_reset.clock_ctl && !group_reset.level_select);
  c_osc: cover property (internal_reset && !group_reset.clock_ctl);
  c_irq: cover property ($rose(irq));
endmodule

bind rsg_reset_guard rsg_reset_guard_props #(.OPTION_SELECT_BYTE(OPTION_SELECT_BYTE)) u_props (
  .clk(clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata), .reset_pin_n(reset_pin_n),
  .supply_below_first_level(supply_below_first_level), .monitor_two_trip(monitor_two_trip),
  .slow_internal_osc_clock(slow_internal_osc_clock), .watchdog_underflow(watchdog_underflow),
  .other_sfr_write(other_sfr_write), .internal_reset(internal_reset), .group_reset(group_reset),
  .guard_enable_mode_regs(guard_enable_mode_regs), .guard_enable_one_shot(guard_enable_one_shot),
  .processor_mode_0_out(processor_mode_0_out), .irq(irq));

// file: tb/tb.sv
`timescale 1ns/100ps
module tb;
  import rsg_pkg::*;
  logic clk, rst, reset_pin_n, supply_below_first_level, monitor_two_trip, osc_stopped;
  logic slow_internal_osc_clock, watchdog_underflow, reset_on_osc_stop_select;
  logic monitor_zero_sw_enable, other_sfr_write, internal_reset, irq;
  logic g0, g1, g2, g3, g6;
  rsg_bus_req_t bus_req;
  rsg_group_reset_t group_reset;
  logic [7:0] bus_rdata, processor_mode_0_out, rd_val;
  logic [1:0] slow_div;
  int fail_count, samples_checked, cycles;

  rsg_reset_guard uut (.clk(clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .reset_pin_n(reset_pin_n), .supply_below_first_level(supply_below_first_level),
    .monitor_two_trip(monitor_two_trip), .osc_stopped(osc_stopped),
    .slow_internal_osc_clock(slow_internal_osc_clock), .watchdog_underflow(watchdog_underflow),
    .reset_on_osc_stop_select(reset_on_osc_stop_select),
    .monitor_zero_sw_enable(monitor_zero_sw_enable), .other_sfr_write(other_sfr_write),
    .internal_reset(internal_reset), .group_reset(group_reset), .guard_enable_zero(g0),
    .guard_enable_mode_regs(g1), .guard_enable_one_shot(g2), .guard_enable_three(g3),
    .guard_enable_six(g6), .processor_mode_0_out(processor_mode_0_out), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Slow oscillator at a quarter of the system clock keeps runs short
  always @(posedge clk) begin
    slow_div <= slow_div + 2'h1;
    slow_internal_osc_clock <= slow_div[1];
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      fail_count = fail_count + 1;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk) bus_req <= {a, d, 2'b10};
    @(posedge clk) bus_req <= {a, d, 2'b00};
  endtask
  task automatic bus_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk) bus_req <= {a, 8'h00, 2'b01};
    @(posedge clk) bus_req <= {a, 8'h00, 2'b00};
    @(negedge clk) d = bus_rdata;
  endtask
  task automatic settle();
    repeat (2) @(negedge clk);
  endtask
  function automatic logic [7:0] guards();
    return {3'h0, g6, g3, g2, g1, g0};
  endfunction
  task automatic wait_for(input logic lvl, input int lim);
    int n;
    n = 0;
    while (internal_reset !== lvl && n < lim) begin
      @(negedge clk);
      n = n + 1;
    end
    check({7'h0, internal_reset}, {7'h0, lvl}, "internal_reset");
  endtask
  task automatic do_cause(input logic [3:0] grp, input logic [7:0] flags);
    wait_for(1'b1, 12);
    settle();
    check({4'h0, group_reset}, {4'h0, grp}, "group_reset");
    wait_for(1'b0, 1200);
    bus_rd(ADDR_RESET_CAUSE_FLAGS, rd_val);
    check(rd_val, flags, "reset_cause_flags");
  endtask
  task automatic pulse_level(input int sel);
    @(posedge clk) begin
      if (sel == 0) reset_pin_n <= 1'b0;
      else if (sel == 1) supply_below_first_level <= 1'b1;
      else monitor_two_trip <= 1'b1;
    end
    repeat (10) @(posedge clk);
    reset_pin_n <= 1'b1;
    supply_below_first_level <= 1'b0;
    monitor_two_trip <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_power();
    wait_for(1'b0, 1200);
    bus_rd(ADDR_RESET_CAUSE_FLAGS, rd_val);
    check(rd_val, 8'h00, "flags after power");
    bus_wr(ADDR_OPTION_SELECT_BYTE, 8'h00);
    bus_rd(ADDR_OPTION_SELECT_BYTE, rd_val);
    check(rd_val, 8'hff, "option byte");
    bus_rd(16'h0030, rd_val);
    check(rd_val, 8'h00, "unmapped read");
    $display("power test done");
  endtask
  task automatic t_guard();
    bus_wr(ADDR_WRITE_GUARD_CONTROL, 8'h4b);
    settle();
    check(guards(), 8'h1b, "sticky guards set");
    bus_wr(16'h0030, 8'h55);
    other_sfr_write <= 1'b1;
    @(posedge clk) other_sfr_write <= 1'b0;
    settle();
    check(guards(), 8'h1b, "sticky guards kept");
    bus_wr(ADDR_WRITE_GUARD_CONTROL, 8'h00);
    settle();
    check(guards(), 8'h00, "sticky guards cleared");
    $display("guard test done");
  endtask
  task automatic t_one_shot();
    bus_wr(ADDR_WRITE_GUARD_CONTROL, 8'h04);
    settle();
    check(guards(), 8'h04, "one-shot set");
    @(posedge clk) other_sfr_write <= 1'b1;
    @(posedge clk) other_sfr_write <= 1'b0;
    settle();
    check(guards(), 8'h00, "one-shot after sfr write");
    bus_wr(ADDR_WRITE_GUARD_CONTROL, 8'h04);
    bus_wr(16'h0030, 8'h00);
    settle();
    check(guards(), 8'h00, "one-shot after bus write");
    $display("one-shot test done");
  endtask
  task automatic t_mode_block();
    bus_wr(ADDR_IRQ_CLEAR, 8'h07);
    bus_wr(ADDR_IRQ_ENABLE, 8'h01);
    bus_wr(ADDR_PROCESSOR_MODE_0, 8'h01);
    settle();
    check(processor_mode_0_out, 8'h00, "blocked mode write");
    check({7'h0, irq}, 8'h01, "irq on blocked write");
    bus_rd(ADDR_IRQ_STATUS, rd_val);
    check(rd_val & 8'h01, 8'h01, "irq status");
    bus_wr(ADDR_IRQ_CLEAR, 8'h01);
    settle();
    check({7'h0, irq}, 8'h00, "irq cleared");
    bus_wr(ADDR_WRITE_GUARD_CONTROL, 8'h02);
    bus_wr(ADDR_PROCESSOR_MODE_0, 8'h01);
    settle();
    check(processor_mode_0_out, 8'h01, "guarded mode write");
    $display("mode guard test done");
  endtask
  task automatic t_soft_wdt();
    bus_wr(ADDR_PROCESSOR_MODE_0, 8'h08);
    do_cause(4'b1001, 8'h04);
    check(processor_mode_0_out, 8'h00, "mode after soft reset");
    check(guards(), 8'h00, "guards after soft reset");
    @(posedge clk) watchdog_underflow <= 1'b1;
    @(posedge clk) watchdog_underflow <= 1'b0;
    do_cause(4'b1001, 8'h08);
    $display("soft and watchdog test done");
  endtask
  task automatic t_osc_pin();
    pulse_level(2);
    do_cause(4'b1011, 8'h20);
    @(posedge clk) osc_stopped <= 1'b1;
    repeat (10) @(posedge clk);
    check({7'h0, internal_reset}, 8'h00, "stop without reset select");
    reset_on_osc_stop_select <= 1'b0;
    repeat (10) @(posedge clk);
    osc_stopped <= 1'b0;
    reset_on_osc_stop_select <= 1'b1;
    // Stop reset stays held until a pin or power reset cancels it
    wait_for(1'b1, 12);
    settle();
    check({4'h0, group_reset}, 8'h08, "osc stop group_reset");
    repeat (800) @(posedge clk);
    check({7'h0, internal_reset}, 8'h01, "osc stop reset held");
    check({4'h0, group_reset}, 8'h08, "osc stop groups held");
    pulse_level(0);
    do_cause(4'b1111, 8'h42);
    bus_wr(ADDR_RESET_CAUSE_FLAGS, 8'h40);
    bus_rd(ADDR_RESET_CAUSE_FLAGS, rd_val);
    check(rd_val, 8'h42, "osc flag write one");
    pulse_level(1);
    do_cause(4'b1111, 8'h00);
    monitor_zero_sw_enable <= 1'b1;
    pulse_level(0);
    do_cause(4'b1111, 8'h00);
    $display("osc and pin test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    fail_count = 0;
    samples_checked = 0;
    cycles = 0;
    slow_div = 2'h0;
    rst = 1'b1;
    bus_req = '0;
    reset_pin_n = 1'b1;
    supply_below_first_level = 1'b0;
    monitor_two_trip = 1'b0;
    osc_stopped = 1'b0;
    slow_internal_osc_clock = 1'b0;
    watchdog_underflow = 1'b0;
    reset_on_osc_stop_select = 1'b1;
    monitor_zero_sw_enable = 1'b0;
    other_sfr_write = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_power();
    t_guard();
    t_one_shot();
    t_mode_block();
    t_soft_wdt();
    t_osc_pin();
    close_out();
  end
endmodule
